// File: lcc2_pkg.sv
// constants for the second lamp control register
package lcc2_pkg;
	localparam int          REG_W         = 8;
	localparam logic [7:0]  LC2_RESET     = 8'h08;
	localparam int          BIT_WP        = 0;
	localparam int          BIT_RANGE_LO  = 1;
	localparam int          BIT_SAMPLE_LO = 3;
	localparam int          BIT_PD        = 7;
	localparam logic [7:0]  LC2_WR_MASK   = 8'h9f;
	localparam logic [7:0]  LC2_ADDR      = 8'hf5;
	localparam logic [5:0]  DIV_4         = 6'h04;
	localparam logic [5:0]  DIV_8         = 6'h08;
	localparam logic [5:0]  DIV_16        = 6'h10;
	localparam logic [5:0]  DIV_32        = 6'h20;
	typedef enum logic [1:0] {
		RANGE_22_55   = 2'b00,
		RANGE_45_110  = 2'b01,
		RANGE_90_220  = 2'b10,
		RANGE_180_440 = 2'b11
	} lcc2_range_t;
endpackage : lcc2_pkg

// File: lcc2_sampler.sv
// feedback sample strobe every n lamp cycles
`timescale 1ns/1ps
module lcc2_sampler
	import lcc2_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       hold,
	input  wire logic       lamp_tick,
	input  wire logic [1:0] rate_sel,
	output logic            sample_q
);
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic [5:0] period;
	logic       wrap;

	assign period = (rate_sel == 2'b00) ? DIV_4 :
	                (rate_sel == 2'b01) ? DIV_8 :
	                (rate_sel == 2'b10) ? DIV_16 : DIV_32; // R03
	assign wrap   = lamp_tick && (cnt_q >= period - 6'h01);
	assign cnt_d  = hold ? 6'h00 : wrap ? 6'h00 :
	                lamp_tick ? cnt_q + 6'h01 : cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q    <= 6'h00;
			sample_q <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			sample_q <= wrap && !hold; // R03
		end
	end
endmodule : lcc2_sampler

// File: lcc2_ctrl.sv
// second lamp control register with power-down, protect and rate logic
// How it works
// R01 - range field picks burst dimming band 22.5-55, 45-110, 90-220, 180-440 Hz
// R02 - software matches range field to an external dimming clock frequency
// R03 - sample field strobes feedback every 4, 8, 16 or 32 lamp cycles
// R04 - reset value: sample field 01, every other bit zero
// R05 - software writes zero into bits 5 and 6
// R06 - power-down request is register bit ORed with the power-down pin
// R07 - power-down holds controller reset, clears faults, serial bus stays alive
// R08 - protect bit set blocks user memory writes, clear allows them
// R09 - source select chooses resistor oscillator or external 22.5-440 Hz clock
`timescale 1ns/1ps
module lcc2_ctrl
	import lcc2_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   reg_wr,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [REG_W-1:0]       reg_wdata,
	output logic      [REG_W-1:0]       reg_rdata,
	input  wire logic                   powerdown_pin,
	input  wire logic                   dim_osc_source_sel,
	input  wire logic                   dim_osc_input,
	input  wire logic                   dim_osc_internal,
	input  wire logic                   lamp_tick,
	input  wire logic                   fault_in,
	input  wire logic                   umem_wr_req,
	output logic                        umem_wr_en,
	output lcc2_pkg::lcc2_range_t       dim_range,
	output logic                        burst_dimming_clock,
	output logic                        fb_sample_strobe,
	output logic                        fault_q,
	output logic                        powerdown_req,
	output logic                        ctrl_reset
);
	import lcc2_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// true when a bus cycle writes this register
	function automatic logic is_lc2_write(
		input logic       wr,
		input logic [7:0] addr
	);
		return wr && (addr == LC2_ADDR);
	endfunction : is_lc2_write

	// reserved positions forced to zero on every write
	function automatic logic [REG_W-1:0] lc2_clean(
		input logic [REG_W-1:0] data
	);
		return data & LC2_WR_MASK;
	endfunction : lc2_clean

	// two-bit field at a given position
	function automatic logic [1:0] field2(
		input logic [REG_W-1:0] data,
		input int               lsb
	);
		return data[lsb +: 2];
	endfunction : field2

	// ------------------------------------------------------------
	// decoders
	// ------------------------------------------------------------
	// band code to band name
	function automatic lcc2_range_t band_of(
		input logic [1:0] code
	);
		lcc2_range_t band;
		band = RANGE_22_55;
		unique case (code)
			2'b00: band = RANGE_22_55;
			2'b01: band = RANGE_45_110;
			2'b10: band = RANGE_90_220;
			2'b11: band = RANGE_180_440;
		endcase
		return band;
	endfunction : band_of

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	logic [REG_W-1:0] wdata_clean;
	logic             hit_wr;

	assign hit_wr      = is_lc2_write(reg_wr, reg_addr);
	assign wdata_clean = lc2_clean(reg_wdata); // R05

	// ------------------------------------------------------------
	// register
	// ------------------------------------------------------------
	logic [REG_W-1:0] lc2_q;
	logic [REG_W-1:0] lc2_d;

	assign lc2_d = hit_wr ? wdata_clean : lc2_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lc2_q <= LC2_RESET; // R04
		end else begin
			lc2_q <= lc2_d;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// read back straight from the flops, no extra stage
	assign reg_rdata = lc2_q;

	// ------------------------------------------------------------
	// field breakout
	// ------------------------------------------------------------
	logic       user_mem_write_protect;
	logic       powerdown_bit;
	logic       dim_range_sel_lo;
	logic       dim_range_sel_hi;
	logic       fb_sample_sel_lo;
	logic       fb_sample_sel_hi;
	logic [1:0] dim_range_sel;
	logic [1:0] fb_sample_sel;

	assign user_mem_write_protect = lc2_q[BIT_WP];
	assign powerdown_bit          = lc2_q[BIT_PD];
	assign dim_range_sel          = field2(lc2_q, BIT_RANGE_LO);
	assign fb_sample_sel          = field2(lc2_q, BIT_SAMPLE_LO);
	assign dim_range_sel_lo       = dim_range_sel[0];
	assign dim_range_sel_hi       = dim_range_sel[1];
	assign fb_sample_sel_lo       = fb_sample_sel[0];
	assign fb_sample_sel_hi       = fb_sample_sel[1];

	// ------------------------------------------------------------
	// dimming band
	// ------------------------------------------------------------
	logic [1:0] band_code;

	// the chosen band only drives dim_range; the dimming clock path does not use it
	assign band_code = {dim_range_sel_hi, dim_range_sel_lo};
	assign dim_range = band_of(band_code); // R01

	// ------------------------------------------------------------
	// power-down
	// ------------------------------------------------------------
	logic pd_from_reg;
	logic pd_from_pin;

	assign pd_from_reg   = powerdown_bit;
	assign pd_from_pin   = powerdown_pin;
	assign powerdown_req = pd_from_reg | pd_from_pin; // R06
	// the register and serial bus stay out of this reset
	assign ctrl_reset    = powerdown_req; // R07

	// ------------------------------------------------------------
	// fault flag
	// ------------------------------------------------------------
	logic fault_set;
	logic fault_clr;
	logic fault_d;

	// clear wins over a new fault in power-down
	assign fault_set = fault_in;
	assign fault_clr = powerdown_req; // R07
	assign fault_d   = fault_clr ? 1'b0 : (fault_q | fault_set);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_d; // R07
		end
	end

	// ------------------------------------------------------------
	// user memory protect
	// ------------------------------------------------------------
	logic umem_wr_block;

	assign umem_wr_block = user_mem_write_protect; // R08
	assign umem_wr_en    = umem_wr_req && !umem_wr_block; // R08

	// ------------------------------------------------------------
	// dimming clock source
	// ------------------------------------------------------------
	logic dim_src;
	logic dim_clk_d;

	assign dim_src   = dim_osc_source_sel ? dim_osc_input
	                                      : dim_osc_internal; // R09
	// held low in power-down so the lamps stay dark
	assign dim_clk_d = dim_src && !powerdown_req; // R07

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			burst_dimming_clock <= 1'b0;
		end else begin
			burst_dimming_clock <= dim_clk_d; // R09
		end
	end

	// ------------------------------------------------------------
	// feedback sampler
	// ------------------------------------------------------------
	logic [1:0] rate_code;
	logic       sampler_hold;
	logic       tick_live;

	// a rate change mid-count keeps the running count
	assign rate_code    = {fb_sample_sel_hi, fb_sample_sel_lo}; // R03
	assign sampler_hold = powerdown_req; // R07
	// ticks are ignored while the lamp is off
	assign tick_live    = lamp_tick && !powerdown_req;

	lcc2_sampler u_sampler (
		.clk       (clk),
		.rst_n     (rst_n),
		.hold      (sampler_hold),
		.lamp_tick (tick_live),
		.rate_sel  (rate_code),
		.sample_q  (fb_sample_strobe)
	);
endmodule : lcc2_ctrl

// File: lcc2_ctrl_properties.sv
// port checker for the second lamp control register
`timescale 1ns/1ps
module lcc2_ctrl_chk
	import lcc2_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        powerdown_pin,
	input wire logic        dim_osc_source_sel,
	input wire logic        dim_osc_input,
	input wire logic        dim_osc_internal,
	input wire logic        lamp_tick,
	input wire logic        umem_wr_req,
	input wire logic        umem_wr_en,
	input wire lcc2_range_t dim_range,
	input wire logic        burst_dimming_clock,
	input wire logic        fb_sample_strobe,
	input wire logic        fault_q,
	input wire logic        powerdown_req,
	input wire logic        ctrl_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_pd; powerdown_req == (reg_rdata[7] | powerdown_pin); endproperty
	a_pd: assert property (p_pd) else $error("bad power-down request");
	property p_rst; $rose(rst_n) |-> reg_rdata == 8'h08; endproperty
	a_rst: assert property (p_rst) else $error("bad reset value");
	property p_wr; reg_wr && reg_addr == 8'hf5
		|=> reg_rdata == ($past(reg_wdata) & 8'h9f); endproperty
	a_wr: assert property (p_wr) else $error("bad register write");
	property p_um; umem_wr_en == (umem_wr_req & !reg_rdata[0]); endproperty
	a_um: assert property (p_um) else $error("bad write protect");
	property p_rng; dim_range == reg_rdata[2:1]; endproperty
	a_rng: assert property (p_rng) else $error("bad range field");
	property p_flt; powerdown_req |=> !fault_q; endproperty
	a_flt: assert property (p_flt) else $error("fault kept");
	property p_bpd; powerdown_req |=> !burst_dimming_clock; endproperty
	a_bpd: assert property (p_bpd) else $error("dim clock on");
	property p_sel; rst_n && !powerdown_req && dim_osc_source_sel
		|=> burst_dimming_clock == $past(dim_osc_input); endproperty
	a_sel: assert property (p_sel) else $error("bad dim source");
	property p_int; rst_n && !powerdown_req && !dim_osc_source_sel
		|=> burst_dimming_clock == $past(dim_osc_internal); endproperty
	a_int: assert property (p_int) else $error("bad internal source");
	property p_crst; ctrl_reset == powerdown_req; endproperty
	a_crst: assert property (p_crst) else $error("bad ctrl reset");
	property p_stk; fb_sample_strobe |-> $past(lamp_tick); endproperty
	a_stk: assert property (p_stk) else $error("strobe without tick");
	property p_spd; powerdown_req |=> !fb_sample_strobe; endproperty
	a_spd: assert property (p_spd) else $error("strobe in power-down");
endmodule : lcc2_ctrl_chk
bind lcc2_ctrl lcc2_ctrl_chk chk (
	.clk                 (clk),
	.rst_n               (rst_n),
	.reg_wr              (reg_wr),
	.reg_addr            (reg_addr),
	.reg_wdata           (reg_wdata),
	.reg_rdata           (reg_rdata),
	.powerdown_pin       (powerdown_pin),
	.dim_osc_source_sel  (dim_osc_source_sel),
	.dim_osc_input       (dim_osc_input),
	.dim_osc_internal    (dim_osc_internal),
	.lamp_tick           (lamp_tick),
	.umem_wr_req         (umem_wr_req),
	.umem_wr_en          (umem_wr_en),
	.dim_range           (dim_range),
	.burst_dimming_clock (burst_dimming_clock),
	.fb_sample_strobe    (fb_sample_strobe),
	.fault_q             (fault_q),
	.powerdown_req       (powerdown_req),
	.ctrl_reset          (ctrl_reset)
);

// File: tb_lcc2_ctrl.sv
// self-checking bench for the second lamp control register
`timescale 1ns/1ps
module tb_lcc2_ctrl;
	import lcc2_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, pin = 0, osc = 0, tick = 0, flt = 0;
	logic ureq = 0, ue, bdc, stb, fq, pdr, crst;
	logic sel = 0, exp_b = 0;
	logic [7:0] addr = 0, wd = 0, rd;
	lcc2_range_t rng;
	int n_mismatch = 0, checks = 0, n = 0;
	always #25 clk = ~clk;
	always @(posedge clk) osc <= ~osc;
	always @(negedge clk) if (stb === 1'b1) n++;
	lcc2_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_addr(addr),
		.reg_wdata(wd), .reg_rdata(rd), .powerdown_pin(pin),
		.dim_osc_source_sel(sel), .dim_osc_input(osc),
		.dim_osc_internal(~osc), .lamp_tick(tick), .fault_in(flt),
		.umem_wr_req(ureq), .umem_wr_en(ue), .dim_range(rng),
		.burst_dimming_clock(bdc), .fb_sample_strobe(stb), .fault_q(fq),
		.powerdown_req(pdr), .ctrl_reset(crst));
	task automatic cmp(input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask : cmp
	task automatic wreg(input logic [7:0] a, d);
		@(posedge clk) begin
			wr <= 1; addr <= a; wd <= d;
		end
		@(posedge clk) wr <= 0;
		@(negedge clk);
	endtask : wreg
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(negedge clk) cmp(8'h08, rd);
		wreg(8'hf5, 8'h9f);
		cmp(8'h9f, rd);
		cmp(1, pdr);
		cmp(1, crst);
		wreg(8'hf4, 8'h00);
		cmp(8'h9f, rd);
		wreg(8'hf5, 8'h01);
		@(posedge clk) begin
			ureq <= 1; flt <= 1;
		end
		@(posedge clk) flt <= 0;
		@(negedge clk) cmp(0, ue);
		wreg(8'hf5, 8'h00);
		cmp(1, ue);
		cmp(1, fq);
		@(posedge clk) pin <= 1;
		@(negedge clk) cmp(1, pdr);
		@(negedge clk) cmp(0, fq);
		// one pass per range and rate code, counter cleared by power-down
		for (int c = 0; c < 4; c++) begin
			wreg(8'hf5, 8'(c * 10));
			cmp(8'(c), rng);
			@(posedge clk) pin <= 0;
			n = 0;
			repeat (32) begin
				@(posedge clk) tick <= 1;
				@(posedge clk) tick <= 0;
			end
			repeat (3) @(posedge clk);
			cmp(8'(32 >> (c + 2)), 8'(n));
			pin <= 1;
		end
		// dimming clock off in power-down, then each source in turn
		repeat (2) @(negedge clk);
		cmp(0, bdc);
		wreg(8'hf5, 8'h00);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk) begin
				pin <= 0;
				sel <= s[0];
			end
			@(negedge clk) exp_b = s[0] ? osc : ~osc;
			@(negedge clk) cmp(exp_b, bdc);
			cmp(0, crst);
		end
		complete_run();
	end
endmodule : tb_lcc2_ctrl
